/* hdl/dss_sequencer.sv */
/*
 * dual rail source sequencer: picks main or standby supply for the dual rail
 * from the deglitched sleep inputs, mode and supply-ready comparators.
 * assumes rst_b is the standby supply power-on reset, all inputs are
 * asynchronous pins, and a pull-up to the high supply on the main gate pin.
 */
`timescale 1ns/1ps
`include "dss_regs.svh"
module dss_sequencer #(
    parameter int DEGLITCH_CYC   = `DSS_DEGLITCH_CYC,
    parameter int S3_DELAY_CYC   = `DSS_S3_DELAY_CYC,
    parameter int SETTLE_CYC     = `DSS_SETTLE_CYC,
    parameter int SOFT_START_CYC = `DSS_SOFT_START_CYC
) (
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic sleep3_n,
    input  wire logic sleep5_n,
    input  wire logic mode,
    input  wire logic mainSupplyOk,
    input  wire logic mainGateAboveRef,
    output logic      mainGateDriveOut,
    output logic      mainGateDriveOe,
    output logic      standbyGateDrive,
    output logic      standbySoftSink,
    output logic      mainPathOn
);
    // ------------------------------------------------------------
    // input conditioning
    // ------------------------------------------------------------
    logic s3Level;
    logic s5Level;
    logic mainOkA;
    logic mainOkB;
    logic highOkA;
    logic highOkB;

    dss_deglitch #(
        .STABLE_CYC (DEGLITCH_CYC)
    ) u_s3 (
        .clk   (clk),
        .rst_b (rst_b),
        .pinIn (sleep3_n),
        .level (s3Level)
    );

    dss_deglitch #(
        .STABLE_CYC (DEGLITCH_CYC)
    ) u_s5 (
        .clk   (clk),
        .rst_b (rst_b),
        .pinIn (sleep5_n),
        .level (s5Level)
    );

    logic modeA;
    logic modeB;

    // each pair stands alone; only the second stage is read by logic
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mainOkA <= 1'b0;
            mainOkB <= 1'b0;
        end else begin
            mainOkA <= mainSupplyOk;
            mainOkB <= mainOkA;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            highOkA <= 1'b0;
            highOkB <= 1'b0;
        end else begin
            highOkA <= mainGateAboveRef;
            highOkB <= highOkA;
        end
    end

    // mode is a board strap but may still move at run time
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            modeA <= 1'b0;
            modeB <= 1'b0;
        end else begin
            modeA <= mode;
            modeB <= modeA;
        end
    end

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    // sleep5_n low wins over sleep3_n
    wire wantS45     = !s5Level;
    wire wantS3      = s5Level && !s3Level;
    wire wantS0      = s5Level && s3Level;
    wire suppliesOk  = mainOkB && highOkB;

    // ------------------------------------------------------------
    // counters
    // ------------------------------------------------------------
    localparam int TW = $clog2(SETTLE_CYC + SOFT_START_CYC + S3_DELAY_CYC + 2);

    function automatic logic [TW-1:0] lastCount(input int cyc);
        lastCount = TW'(cyc - 1);
    endfunction

    // settle timer runs while S0 is requested and supplies stay ready;
    // any loss of either restarts the full 5 ms
    logic [TW-1:0] settleCnt;
    logic          settled;
    wire           settleArm  = wantS0 && suppliesOk;
    wire           settleLast = settleCnt == lastCount(SETTLE_CYC);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            settleCnt <= '0;
        end else if (!settleArm) begin
            settleCnt <= '0;
        end else if (!settled) begin
            settleCnt <= settleCnt + TW'(1);
        end
    end

    // settled stays up until the request or a supply goes away
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            settled <= 1'b0;
        end else if (!settleArm) begin
            settled <= 1'b0;
        end else if (settleLast) begin
            settled <= 1'b1;
        end
    end

    // S0 is only taken once the settle delay has run out
    wire goMain = wantS0 && settled;

    // ------------------------------------------------------------
    // state helpers
    // ------------------------------------------------------------
    // the S3 wait keeps the main switch closed until its delay ends, a supply drops or S4/S5 is requested
    function automatic logic mainFed(input dss_pkg::dss_state_t s);
        mainFed = (s == dss_pkg::ST_MAIN) || (s == dss_pkg::ST_S3WT);
    endfunction

    function automatic logic standbyFed(input dss_pkg::dss_state_t s);
        standbyFed = s == dss_pkg::ST_STBY;
    endfunction

    // target of an S4/S5 request: standby only if mode keeps the rail
    function automatic dss_pkg::dss_state_t s45Target(input logic keepRail);
        s45Target = keepRail ? dss_pkg::ST_STBY : dss_pkg::ST_OFF;
    endfunction

    // ------------------------------------------------------------
    // state machine
    // ------------------------------------------------------------
    dss_pkg::dss_state_t state;
    dss_pkg::dss_state_t next_state;
    logic [TW-1:0]       timer;
    logic [TW-1:0]       next_timer;
    logic                started;

    wire softDone = timer == lastCount(SOFT_START_CYC);
    wire s3Done   = timer == lastCount(S3_DELAY_CYC);

    // standby path wanted in S3, in S4/S5 with mode high, or in S0 before settling with mode high or once started
    wire standbyWanted = wantS3 || (wantS45 && modeB) || (wantS0 && !settled && modeB)
                         || (wantS0 && !settled && started);

    always_comb begin
        next_state = state;
        next_timer = '0;
        case (state)
            dss_pkg::ST_OFF: begin
                if (goMain) begin
                    next_state = dss_pkg::ST_MAIN;
                end else if (standbyWanted) begin
                    next_state = dss_pkg::ST_SOFT;
                end
            end
            dss_pkg::ST_SOFT: begin
                next_timer = timer + TW'(1);
                if (goMain) begin
                    next_state = dss_pkg::ST_MAIN;
                end else if (!standbyWanted) begin
                    next_state = dss_pkg::ST_OFF;
                end else if (softDone) begin
                    next_state = dss_pkg::ST_STBY;
                end
            end
            dss_pkg::ST_STBY: begin
                if (goMain) begin
                    next_state = dss_pkg::ST_MAIN;
                end else if (!standbyWanted) begin
                    next_state = dss_pkg::ST_OFF;
                end
            end
            dss_pkg::ST_MAIN: begin
                if (wantS45) begin
                    // no added delay on the way to S4/S5
                    next_state = s45Target(modeB);
                end else if (wantS3) begin
                    next_state = dss_pkg::ST_S3WT;
                end else if (!settled) begin
                    // supplies dropped while active: fall back
                    next_state = dss_pkg::ST_STBY;
                end
            end
            dss_pkg::ST_S3WT: begin
                next_timer = timer + TW'(1);
                if (wantS45) begin
                    next_state = s45Target(modeB);
                end else if (goMain) begin
                    next_state = dss_pkg::ST_MAIN;
                end else if (s3Done || !suppliesOk) begin
                    next_state = dss_pkg::ST_STBY;
                end
            end
            default: begin
                next_state = dss_pkg::ST_OFF;
            end
        endcase
        if (next_state != state) begin
            next_timer = '0;
        end
    end

    // started marks that the main switch has once fed the rail since reset, so a
    // supply drop in S0 with mode low keeps standby rather than going dark
    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= dss_pkg::ST_OFF;
        end else begin
            state <= next_state;
        end
    end

    // timer clears on every state change, so each wait starts at zero
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            timer <= '0;
        end else begin
            timer <= next_timer;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            started <= 1'b0;
        end else begin
            started <= started || mainFed(state);
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    wire mainOnNext   = mainFed(next_state);
    wire stbyOnNext   = standbyFed(next_state);
    wire softOnNext   = next_state == dss_pkg::ST_SOFT;

    // main and standby gates change in the same edge, so no gap on the rail
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mainPathOn <= 1'b0;
        end else begin
            mainPathOn <= mainOnNext;
        end
    end

    // open-drain pin: data stays low, only the enable moves
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mainGateDriveOut <= 1'b0;
        end else begin
            mainGateDriveOut <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mainGateDriveOe <= 1'b1;
        end else begin
            mainGateDriveOe <= !mainOnNext;
        end
    end

    // standby gate is active low: 0 turns the PMOS fully on
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            standbyGateDrive <= 1'b1;
        end else begin
            standbyGateDrive <= !stbyOnNext;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            standbySoftSink <= 1'b0;
        end else begin
            standbySoftSink <= softOnNext;
        end
    end
endmodule

/* hdl/dss_regs.svh */
/*
 * constants for the dual rail sleep state switch sequencer: timing figures
 * and reset values. assumes a 125 MHz clock; included by bare name.
 */
`ifndef DSS_REGS_SVH
`define DSS_REGS_SVH

`define DSS_CLK_MHZ          125
`define DSS_S3_DELAY_US      120
`define DSS_SETTLE_MS        5
`define DSS_S3_DELAY_CYC     (`DSS_S3_DELAY_US * `DSS_CLK_MHZ)
`define DSS_SETTLE_CYC       (`DSS_SETTLE_MS * 1000 * `DSS_CLK_MHZ)
`define DSS_DEGLITCH_CYC     64
`define DSS_SOFT_START_CYC   125000
`define DSS_SLEEP_RESET      1'b0

`endif

/* hdl/dss_pkg.sv */
/*
 * types for the sequencer. assumes nothing else.
 */
package dss_pkg;
    typedef enum logic [2:0] {
        ST_OFF   = 3'b000,
        ST_STBY  = 3'b001,
        ST_SOFT  = 3'b010,
        ST_MAIN  = 3'b011,
        ST_S3WT  = 3'b100
    } dss_state_t;
endpackage

/* hdl/dss_deglitch.sv */
/*
 * deglitch filter for one slow input: two-stage synchroniser then a
 * stability counter. assumes one clock, asynchronous active-low reset.
 */
`timescale 1ns/1ps
`include "dss_regs.svh"
module dss_deglitch #(
    parameter int STABLE_CYC = `DSS_DEGLITCH_CYC
) (
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic pinIn,
    output logic      level
);
    localparam int CW = $clog2(STABLE_CYC + 1);

    logic          syncA;
    logic          syncB;
    logic [CW-1:0] count;

    wire           differs = syncB != level;
    wire           expired = count == CW'(STABLE_CYC - 1);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            syncA <= `DSS_SLEEP_RESET;
            syncB <= `DSS_SLEEP_RESET;
        end else begin
            syncA <= pinIn;
            syncB <= syncA;
        end
    end

    // a new level is taken only after STABLE_CYC equal samples
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            count <= '0;
            level <= `DSS_SLEEP_RESET;
        end else if (!differs) begin
            count <= '0;
        end else if (expired) begin
            count <= '0;
            level <= syncB;
        end else begin
            count <= count + CW'(1);
        end
    end
endmodule

/* test/dss_seq_asserts.sv */
/* port checker for dss_sequencer.
   assumes the bench's short timing: deglitch 4, s3 wait 20, settle 50, soft 30. */
`timescale 1ns/1ps
module dss_seq_asserts (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic sleep3_n,
    input wire logic sleep5_n,
    input wire logic mode,
    input wire logic mainSupplyOk,
    input wire logic mainGateAboveRef,
    input wire logic mainGateDriveOut,
    input wire logic mainGateDriveOe,
    input wire logic standbyGateDrive,
    input wire logic standbySoftSink,
    input wire logic mainPathOn
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence s5Held;
        !sleep5_n [*8];
    endsequence
    sequence offReq;
        (!mode && !sleep5_n) [*8];
    endsequence
    a_od_data_low: assert property (mainGateDriveOut == 1'b0)
        else $error("main gate data not low");
    a_path_gate_tie: assert property (mainPathOn == !mainGateDriveOe)
        else $error("main path and gate release disagree");
    a_no_overlap: assert property (mainPathOn |-> standbyGateDrive && !standbySoftSink)
        else $error("both switches on");
    a_supply_first: assert property ($rose(mainPathOn) |-> $past(mainSupplyOk, 40) && $past(mainGateAboveRef, 40))
        else $error("main on without settled supplies");
    a_s5_main_off: assert property (s5Held |=> ##1 !mainPathOn)
        else $error("main on in s4 s5");
    a_s3_wait: assert property ($fell(mainPathOn) && sleep5_n && !sleep3_n |-> !$past(sleep3_n, 24))
        else $error("s3 entry too early");
    a_mode0_off: assert property (offReq |=> ##1 standbyGateDrive && mainGateDriveOe && !standbySoftSink)
        else $error("rail not shut down");
    a_soft_len: assert property ($rose(standbySoftSink) |-> standbySoftSink [*8] ##[21:24] $fell(standbySoftSink))
        else $error("soft start length wrong");
    a_soft_full: assert property ($fell(standbySoftSink) && mode && !mainPathOn |-> !standbyGateDrive)
        else $error("standby not full after soft start");
    a_soft_gate: assert property (standbySoftSink |-> standbyGateDrive && !mainPathOn)
        else $error("soft sink with gate driven");
endmodule
bind dss_sequencer dss_seq_asserts chk_u (.clk, .rst_b, .sleep3_n, .sleep5_n, .mode,
    .mainSupplyOk, .mainGateAboveRef, .mainGateDriveOut, .mainGateDriveOe,
    .standbyGateDrive, .standbySoftSink, .mainPathOn);

/* test/dss_host_model.sv */
/* host sleep outputs and supply comparators.
   assumes requests change on clock edges; req is {sleep5, sleep3} levels. */
`timescale 1ns/1ps
module dss_host_model (
    input  wire logic       clk,
    input  wire logic [1:0] req,
    input  wire logic       supplyOn,
    input  wire logic       glitch,
    input  wire logic       highOff,
    output logic            sleep3_n = 1'b0,
    output logic            sleep5_n = 1'b0,
    output logic            mainSupplyOk = 1'b0,
    output logic            mainGateAboveRef = 1'b0
);
    // glitch is a short false s5 pulse, only on command
    always @(posedge clk) begin
        sleep5_n <= req[1] & ~glitch;
        sleep3_n <= req[0];
        mainSupplyOk <= supplyOn;
        // highOff holds the high supply below its reference on its own
        mainGateAboveRef <= supplyOn & ~highOff;
    end
endmodule

/* test/dual_rail_sleep_state_switch_sequencer_tb_top.sv */
/* bench for dss_sequencer with the host model.
   assumes short timing parameters; outs = {gate oe, standby gate, sink, main}. */
`timescale 1ns/1ps
module dual_rail_sleep_state_switch_sequencer_tb_top;
    logic       clk = 1'b0;
    logic       rst_b = 1'b0;
    logic       mode = 1'b0;
    logic [1:0] req = 2'h0;
    logic       supplyOn = 1'b0;
    logic       glitch = 1'b0;
    logic       highOff = 1'b0;
    wire        s3n, s5n, mOk, gOk, gOut, gOe, sbDrv, sink, mOn;
    wire  [3:0] outs = {gOe, sbDrv, sink, mOn};
    int         fail_count = 0;
    int         n_checks = 0;
    initial forever #4 clk = ~clk;
    dss_host_model host_u (.clk, .req, .supplyOn, .glitch, .highOff, .sleep3_n(s3n),
        .sleep5_n(s5n),
        .mainSupplyOk(mOk), .mainGateAboveRef(gOk));
    dss_sequencer #(.DEGLITCH_CYC(4), .S3_DELAY_CYC(20), .SETTLE_CYC(50),
        .SOFT_START_CYC(30)) dut_u (.clk, .rst_b, .sleep3_n(s3n), .sleep5_n(s5n),
        .mode, .mainSupplyOk(mOk), .mainGateAboveRef(gOk), .mainGateDriveOut(gOut),
        .mainGateDriveOe(gOe), .standbyGateDrive(sbDrv), .standbySoftSink(sink),
        .mainPathOn(mOn));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic drive(input logic [1:0] r, input logic s, input logic m);
        @(posedge clk);
        req <= r;
        supplyOn <= s;
        mode <= m;
        #1;
    endtask
    task automatic chk(input logic [3:0] exp);
        n_checks++;
        // open-drain data must stay low in every state
        if (outs !== exp || gOut !== 1'b0) begin
            fail_count++;
            $display("[FAIL] %0t outs %b od %b expected %b", $time, outs, gOut, exp);
        end
    endtask
    task automatic rst(input logic m);
        @(posedge clk);
        rst_b <= 1'b0;
        drive(2'h0, 1'b0, m);
        cyc(12);
        @(posedge clk);
        rst_b <= 1'b1;
        #1;
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_mode_low;
        rst(1'b0);
        cyc(1);
        chk(4'hc);
        drive(2'h3, 1'b0, 1'b0);
        cyc(60);
        chk(4'hc);
        @(posedge clk) highOff <= 1'b1;
        drive(2'h3, 1'b1, 1'b0);
        cyc(60);
        chk(4'hc);
        @(posedge clk) highOff <= 1'b0;
        cyc(40);
        chk(4'hc);
        cyc(20);
        chk(4'h5);
        @(posedge clk) glitch <= 1'b1;
        @(posedge clk) glitch <= 1'b0;
        cyc(20);
        chk(4'h5);
        drive(2'h2, 1'b1, 1'b0);
        cyc(15);
        chk(4'h5);
        cyc(25);
        chk(4'h8);
        drive(2'h0, 1'b1, 1'b0);
        cyc(12);
        chk(4'hc);
        $display("test mode_low done");
    endtask
    task automatic t_mode_high;
        rst(1'b1);
        cyc(5);
        chk(4'he);
        cyc(40);
        chk(4'h8);
        drive(2'h3, 1'b0, 1'b1);
        cyc(60);
        chk(4'h8);
        drive(2'h3, 1'b1, 1'b1);
        cyc(60);
        chk(4'h5);
        drive(2'h1, 1'b1, 1'b1);
        cyc(12);
        chk(4'h8);
        $display("test mode_high done");
    endtask
    initial begin
        t_mode_low();
        t_mode_high();
        final_report();
    end
    initial begin
        #(8 * 3000);
        fail_count++;
        final_report();
    end
endmodule
